// ===== core/sras_slave.sv
`timescale 1ns/100ps

// Overview of operation
// - the block is only a serial slave; the master drives select, clock and data in, the block drives data out.
// - the shared pins act as the serial port when the select strap is high or floating, high being the default.
// - transfers use clock phase one, data changing on the first edge of a bit and captured on the second.
// - after reset the block refuses serial register access for up to 350 ms while the controller starts; loader writes pass.
// - register space is paged, each page holding 256 byte addresses of which only some exist.
// - strap levels are caught as configuration when the reset sequence ends, floating giving the pull value.
// - serial mode and loader mode reach the same register space, only the strapped one being active.
// - the clock idles high and toggles only during transfers.
// - outputs change on the falling clock edge and are sampled on the rising edge.
// - each transfer is a command byte, then an address byte, then data bytes.
// - command bit 4 picks normal or fast, bits 7:5 are 011b or a read offset, bits 3:1 the target unit, bit 0 read or write.
module sras_slave import sras_pkg::*; #(
	parameter int BUSY_LEN = BUSY_CYCLES,
	parameter logic [2:0] UNIT_ID = UNIT_DEFAULT
) (
	// system
	input wire logic mclk,
	input wire logic rst_n,
	// strap
	input wire logic if_sel_strap,
	// serial link
	input wire logic sck,
	input wire logic ss_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	// loader side
	input wire logic ee_valid,
	input wire logic [7:0] ee_addr,
	input wire logic [7:0] ee_wdata,
	// register space
	output sras_acc_t acc,
	input wire logic [7:0] acc_rdata,
	// status
	output logic spi_mode,
	output logic reg_busy
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic cmd_ok(input logic [7:0] c);
		logic fast;
		fast = c[CMD_MODE_BIT];
		cmd_ok = (fast || c[CMD_TAG_LSB+:3] == NORMAL_TAG)
			&& c[CMD_UNIT_LSB+:3] == UNIT_ID;
	endfunction

	function automatic logic [7:0] rd_base(input logic [7:0] c, input logic [7:0] a);
		rd_base = c[CMD_MODE_BIT] ? 8'(a + {5'h00, c[CMD_TAG_LSB+:3]}) : a;
	endfunction

	sras_core_t m_r, m_nxt;
	sras_frame_t f_r, f_nxt;
	sras_link_t l_r, l_nxt;
	logic miso_r;
	logic frame_rst;
	logic [7:0] rx_byte;

	// ----------------------------------------------------------------
	// link domain: frame decoding
	// ----------------------------------------------------------------
	// select high clears the frame asynchronously, since the clock stops between frames
	assign frame_rst = ss_n | m_r.link_rst;
	assign rx_byte = {f_r.rx_sh, mosi};

	always_comb begin
		f_nxt = f_r;
		l_nxt = l_r;
		l_nxt.ack_s1 = m_r.ack;
		l_nxt.ack_s2 = l_r.ack_s1;
		f_nxt.rx_sh = rx_byte[6:0];
		f_nxt.bit_cnt = 3'(f_r.bit_cnt + 3'h1);
		f_nxt.tx_sh = {f_r.tx_sh[6:0], 1'b0};
		if (f_r.bit_cnt == 3'h7) begin
			unique case (f_r.phase)
				SRAS_CMD: begin
					f_nxt.cmd = rx_byte;
					f_nxt.ok = cmd_ok(rx_byte);
					f_nxt.phase = SRAS_ADDR;
				end
				SRAS_ADDR: begin
					f_nxt.addr = rx_byte;
					f_nxt.phase = SRAS_DATA;
					f_nxt.tx_sh = TX_IDLE;
					if (f_r.ok && !f_r.cmd[CMD_RW_BIT]) begin
						l_nxt.rd_addr = rd_base(f_r.cmd, rx_byte);
						l_nxt.rd_tgl = ~l_r.rd_tgl;
					end
				end
				SRAS_DATA: begin
					if (f_r.ok && f_r.cmd[CMD_RW_BIT]) begin
						// write offsets are not supported, so data lands from the base up
						l_nxt.wr_addr = f_r.addr;
						l_nxt.wr_data = rx_byte;
						l_nxt.wr_tgl = ~l_r.wr_tgl;
						f_nxt.addr = 8'(f_r.addr + 8'h01);
					end else if (f_r.ok) begin
						// a fetch not yet answered reads as idle rather than stale data
						f_nxt.tx_sh = (l_r.ack_s2 == l_r.rd_tgl) ? m_r.rd_hold : TX_IDLE;
						l_nxt.rd_addr = 8'(l_r.rd_addr + 8'h01);
						l_nxt.rd_tgl = ~l_r.rd_tgl;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			f_r <= '{phase: SRAS_CMD, bit_cnt: 3'h0, rx_sh: 7'h00, cmd: 8'h00,
				addr: 8'h00, ok: 1'b0, tx_sh: TX_IDLE};
		end else begin
			f_r <= f_nxt;
		end
	end

	always_ff @(posedge sck or posedge m_r.link_rst) begin
		if (m_r.link_rst) begin
			l_r <= '0;
		end else begin
			l_r <= l_nxt;
		end
	end

	// falling edge drives the next bit so it is stable at the master's rising edge
	always_ff @(negedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			miso_r <= 1'b0;
		end else begin
			miso_r <= f_r.tx_sh[7];
		end
	end

	// ----------------------------------------------------------------
	// core domain: strap, busy window, register access
	// ----------------------------------------------------------------
	always_comb begin
		m_nxt = m_r;
		m_nxt.link_rst = 1'b0;
		m_nxt.ss_s1 = ss_n;
		m_nxt.ss_s2 = m_r.ss_s1;
		m_nxt.strap_s1 = if_sel_strap;
		m_nxt.strap_s2 = m_r.strap_s1;
		m_nxt.wr_s = {m_r.wr_s[1:0], l_r.wr_tgl};
		m_nxt.rd_s = {m_r.rd_s[1:0], l_r.rd_tgl};
		m_nxt.acc.valid = 1'b0;
		// the register space answers a cycle after the read pulse, so capture then
		m_nxt.rd_pend = m_r.acc.valid && !m_r.acc.write;
		if (m_r.busy) begin
			m_nxt.busy_cnt = BUSY_W'(m_r.busy_cnt + 1'b1);
			if (m_r.busy_cnt == BUSY_W'(BUSY_LEN - 1)) begin
				m_nxt.busy = 1'b0;
			end
		end
		if (!m_r.strap_done && m_r.busy_cnt == STRAP_SETTLE) begin
			m_nxt.spi_mode = m_r.strap_s2;
			m_nxt.strap_done = 1'b1;
		end
		if (m_r.rd_pend) begin
			m_nxt.rd_hold = acc_rdata;
			m_nxt.ack = m_r.rd_s[2];
		end
		if (m_r.spi_mode && m_r.strap_done) begin
			// events during the busy window are consumed by the edge tracking and dropped
			if (!m_r.busy && m_r.wr_s[2] != m_r.wr_s[1]) begin
				m_nxt.acc = '{valid: 1'b1, write: 1'b1, addr: l_r.wr_addr,
					wdata: l_r.wr_data};
			end else if (!m_r.busy && m_r.rd_s[2] != m_r.rd_s[1]) begin
				m_nxt.acc = '{valid: 1'b1, write: 1'b0, addr: l_r.rd_addr,
					wdata: 8'h00};
			end
		end else if (!m_r.spi_mode && ee_valid) begin
			m_nxt.acc = '{valid: 1'b1, write: 1'b1, addr: ee_addr, wdata: ee_wdata};
		end
		m_nxt.miso_oe = m_r.spi_mode && m_r.strap_done && !m_r.ss_s2;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			m_r <= '{link_rst: 1'b1, ss_s1: 1'b1, ss_s2: 1'b1, strap_s1: STRAP_RST,
				strap_s2: STRAP_RST, spi_mode: STRAP_RST, strap_done: 1'b0,
				busy_cnt: '0, busy: 1'b1, wr_s: 3'h0, rd_s: 3'h0, rd_pend: 1'b0,
				ack: 1'b0, rd_hold: 8'h00, miso_oe: 1'b0, acc: '0};
		end else begin
			m_r <= m_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// miso is a link-domain flop; its enable follows select three core cycles late
	assign miso = miso_r;
	assign miso_oe = m_r.miso_oe;
	assign acc = m_r.acc;
	assign spi_mode = m_r.spi_mode;
	assign reg_busy = m_r.busy;

endmodule // sras_slave

// ===== core/sras_pkg.sv
package sras_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int MCLK_HZ = 40_000_000;
	localparam int MCLK_PERIOD_NS = 1_000_000_000 / MCLK_HZ;
	localparam int BUSY_TIME_MS = 350;
	localparam int BUSY_CYCLES = BUSY_TIME_MS * (MCLK_HZ / 1000);
	localparam int BUSY_W = 24;
	localparam int SCK_MAX_MHZ = 25;
	localparam int SS_GAP_NS = 200;
	localparam int SS_GAP_CYCLES = (SS_GAP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam logic [BUSY_W-1:0] STRAP_SETTLE = 24'h000003;

	// ----------------------------------------------------------------
	// command byte layout
	// ----------------------------------------------------------------
	localparam int CMD_RW_BIT = 0;
	localparam int CMD_UNIT_LSB = 1;
	localparam int CMD_MODE_BIT = 4;
	localparam int CMD_TAG_LSB = 5;
	localparam logic [2:0] NORMAL_TAG = 3'h3;
	localparam logic [2:0] UNIT_DEFAULT = 3'h0;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic STRAP_RST = 1'b1;
	localparam logic [7:0] TX_IDLE = 8'h00;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SRAS_CMD = 2'b00,
		SRAS_ADDR = 2'b01,
		SRAS_DATA = 2'b11
	} sras_phase_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sras_acc_t;

	typedef struct packed {
		sras_phase_t phase;
		logic [2:0] bit_cnt;
		logic [6:0] rx_sh;
		logic [7:0] cmd;
		logic [7:0] addr;
		logic ok;
		logic [7:0] tx_sh;
	} sras_frame_t;

	typedef struct packed {
		logic wr_tgl;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
		logic rd_tgl;
		logic [7:0] rd_addr;
		logic ack_s1;
		logic ack_s2;
	} sras_link_t;

	typedef struct packed {
		logic link_rst;
		logic ss_s1;
		logic ss_s2;
		logic strap_s1;
		logic strap_s2;
		logic spi_mode;
		logic strap_done;
		logic [BUSY_W-1:0] busy_cnt;
		logic busy;
		logic [2:0] wr_s;
		logic [2:0] rd_s;
		logic rd_pend;
		logic ack;
		logic [7:0] rd_hold;
		logic miso_oe;
		sras_acc_t acc;
	} sras_core_t;

endpackage

// ===== sim/sras_chk_sva.sv
`timescale 1ns/100ps
module sras_chk import sras_pkg::*; #(
	parameter int BUSY_LEN = 20
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// link
	input wire logic ss_n,
	input wire logic miso,
	input wire logic miso_oe,
	// loader and register side
	input wire logic ee_valid,
	input wire logic [7:0] ee_addr,
	input wire logic [7:0] ee_wdata,
	input wire sras_acc_t acc,
	input wire logic spi_mode,
	input wire logic reg_busy
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	int cnt_r;
	always_ff @(posedge mclk) cnt_r <= rst_n ? cnt_r + 1 : 0;
	// enable is registered in the core domain, so allow its lag
	sequence sel_idle;
		ss_n[*3];
	endsequence
	sequence sel_held;
		(!ss_n)[*3];
	endsequence
	busy_no_acc_a: assert property (reg_busy && spi_mode |-> !acc.valid)
		else $error("access during busy");
	sel_release_a: assert property (sel_idle |=> !miso_oe)
		else $error("output driven while idle");
	sel_drive_a: assert property (spi_mode && !reg_busy ##0 sel_held |=> miso_oe)
		else $error("output not driven while selected");
	idle_low_a: assert property (ss_n[*2] |-> !miso)
		else $error("data out not low while idle");
	acc_pulse_a: assert property (acc.valid |=> !acc.valid)
		else $error("access longer than a cycle");
	loader_pass_a: assert property (!spi_mode && ee_valid |=> acc.valid && acc.write
		&& acc.addr == $past(ee_addr) && acc.wdata == $past(ee_wdata)) else $error("loader lost");
	mode_hold_a: assert property (!reg_busy |-> $stable(spi_mode))
		else $error("strap not held");
	reset_state_a: assert property (disable iff (1'b0) !rst_n |=> reg_busy && spi_mode
		&& !acc.valid && !miso_oe) else $error("reset state wrong");
	busy_len_a: assert property ($fell(reg_busy) |-> cnt_r == BUSY_LEN)
		else $error("busy length wrong");
endmodule // sras_chk

// ===== sim/sras_master.sv
`timescale 1ns/100ps
module sras_master (
	// serial link
	output logic sck,
	output logic ss_n,
	output logic mosi,
	input wire logic miso
);
	logic [7:0] tx [6];
	logic [7:0] rx [6];
	initial begin
		sck = 1'b1;
		ss_n = 1'b1;
		mosi = 1'b0;
	end
	// gap stretches sck high between bytes so read data can cross domains
	task automatic frame(input int n, input int gap);
		ss_n = 1'b0;
		#20;
		for (int i = 0; i < n; i++) begin
			for (int b = 7; b >= 0; b--) begin
				sck = 1'b0;
				mosi = tx[i][b];
				#7.5 sck = 1'b1;
				rx[i][b] = miso;
				#7.5;
			end
			#(gap);
		end
		ss_n = 1'b1;
		mosi = ~mosi;
		#250;
	endtask
endmodule // sras_master

// ===== sim/serial_register_access_slave_tb_top.sv
`timescale 1ns/100ps
module serial_register_access_slave_tb_top import sras_pkg::*;;
	logic mclk = 1'b0, rst_n = 1'b0, strap = 1'b1, ee_valid = 1'b0;
	logic [7:0] ee_addr = 8'h00, ee_wdata = 8'h00, acc_rdata = 8'h00, d;
	logic sck, ss_n, mosi, miso, miso_oe, spi_mode, reg_busy;
	sras_acc_t acc;
	logic [7:0] mem [256];
	logic [16:0] exp_q [$];
	int n_mismatch = 0, checks = 0;
	logic [31:0] rs = 32'h0000000a;
	always #12.5 mclk = ~mclk;
	sras_slave #(.BUSY_LEN(20)) i_sras_slave (.mclk(mclk), .rst_n(rst_n), .if_sel_strap(strap),
		.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .ee_valid(ee_valid),
		.ee_addr(ee_addr), .ee_wdata(ee_wdata), .acc(acc), .acc_rdata(acc_rdata),
		.spi_mode(spi_mode), .reg_busy(reg_busy));
	sras_master i_sras_master (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso));
	function automatic logic [7:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs[7:0];
	endfunction
	task automatic cmp(input string what, input logic [16:0] e, input logic [16:0] s);
		checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic close_out();
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge mclk) begin
		acc_rdata <= mem[acc.addr];
		if (acc.valid && acc.write)
			cmp("write", exp_q.size() ? exp_q.pop_front() : 'x, {1'b1, acc.addr, acc.wdata});
	end
	task automatic wr(input logic [7:0] cmd, input logic [7:0] a, input int n, input bit take);
		i_sras_master.tx[0] = cmd;
		i_sras_master.tx[1] = a;
		for (int k = 0; k < n; k++) begin
			i_sras_master.tx[k + 2] = rnd();
			if (take) begin
				exp_q.push_back({1'b1, a + 8'(k), i_sras_master.tx[k + 2]});
				mem[a + 8'(k)] = i_sras_master.tx[k + 2];
			end
		end
		i_sras_master.frame(n + 2, 0);
		repeat (8) @(posedge mclk);
	endtask
	task automatic rd(input logic [7:0] cmd, input logic [7:0] a, input int n);
		i_sras_master.tx = '{cmd, a, 8'h00, 8'h00, 8'h00, 8'h00};
		i_sras_master.frame(n + 2, 300);
		for (int k = 0; k < n; k++)
			cmp("read", k ? mem[a + 8'(cmd[4] ? cmd[7:5] : 3'h0) + 8'(k - 1)] : 8'h00,
				i_sras_master.rx[k + 2]);
	endtask
	initial begin
		fork
			begin
				#300000;
				n_mismatch++;
				close_out();
			end
		join_none
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		wr(8'h61, 8'h40, 1, 0);
		for (int i = 0; i < 100 && reg_busy; i++) @(posedge mclk);
		cmp("busy", 0, reg_busy);
		cmp("mode", 1, spi_mode);
		wr(8'h61, 8'h20, 4, 1);
		wr(8'h21, 8'h40, 1, 0);
		wr(8'h63, 8'h40, 1, 0);
		wr(8'h51, 8'h50, 1, 1);
		rd(8'h60, 8'h20, 4);
		rd(8'h50, 8'h20, 3);
		for (int i = 0; i < 3; i++) wr(8'h61, rnd(), 2, 1);
		rst_n <= 1'b0;
		strap <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (30) @(posedge mclk);
		cmp("mode", 0, spi_mode);
		wr(8'h61, 8'h30, 1, 0);
		d = rnd();
		exp_q.push_back({1'b1, 8'h31, d});
		ee_addr <= 8'h31;
		ee_wdata <= d;
		ee_valid <= 1'b1;
		@(posedge mclk);
		ee_valid <= 1'b0;
		repeat (4) @(posedge mclk);
		cmp("left", 0, exp_q.size());
		close_out();
	end
endmodule // serial_register_access_slave_tb_top
bind sras_slave sras_chk #(.BUSY_LEN(BUSY_LEN)) i_sras_chk (.mclk(mclk), .rst_n(rst_n),
	.ss_n(ss_n), .miso(miso), .miso_oe(miso_oe), .ee_valid(ee_valid), .ee_addr(ee_addr),
	.ee_wdata(ee_wdata), .acc(acc), .spi_mode(spi_mode), .reg_busy(reg_busy));
